/* asr_pkg.sv */
package asr_pkg;

  // sizes
  localparam int MAX_CHAN = 8;
  localparam int DATA_W = 10;
  localparam int RX_CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int BUS_W = 32;
  localparam int REV_W = 12;
  localparam int VAR_W = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CHEN_SET_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] CHEN_CLR_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] CHEN_STATE_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h1C;
  localparam logic [ADDR_W-1:0] LAST_RESULT_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] IRQ_SET_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 8'h28;
  localparam logic [ADDR_W-1:0] IRQ_VIEW_OFS = 8'h2C;
  localparam logic [ADDR_W-1:0] CHAN_DATA0_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] CHAN_DATA_LAST_OFS = 8'h4C;
  localparam logic [ADDR_W-1:0] FLAG_CLR_OFS = 8'h50;
  localparam logic [ADDR_W-1:0] REVISION_OFS = 8'hFC;

  // status layout, shared by the irq enable registers
  localparam int EOC_LSB = 0;
  localparam int OVR_LSB = 8;
  localparam int DATA_READY_FLAG_BIT = 16;
  localparam int GOVR_BIT = 17;
  localparam int END_OF_RECEIVE_FLAG_BIT = 18;
  localparam int RECEIVE_BUFFER_FULL_FLAG_BIT = 19;
  localparam int REV_LSB = 0;
  localparam int VAR_LSB = 16;
  localparam logic [BUS_W-1:0] FLAG_MASK = 32'h000F_FFFF;
  localparam logic [BUS_W-1:0] STATUS_RESET = 32'h000C_0000;

  // one finished conversion from the analog core
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [DATA_W-1:0] data;
  } asr_conv_s;

  // receive counters of the attached dma channel
  typedef struct packed {
    logic [RX_CNT_W-1:0] count;
    logic [RX_CNT_W-1:0] nextCount;
    logic counterWr;
  } asr_rx_s;

  typedef struct packed {
    logic waitReq;
    logic [BUS_W-1:0] rdData;
    logic irq;
    logic [MAX_CHAN-1:0] chanEn;
    logic [MAX_CHAN-1:0] eoc;
    logic [MAX_CHAN-1:0] ovr;
    logic dataReady;
    logic genOvr;
    logic end_of_receive_flag;
    logic receive_buffer_full_flag;
    logic [BUS_W-1:0] irqMask;
    logic [DATA_W-1:0] lastData;
    logic [MAX_CHAN-1:0][DATA_W-1:0] chanData;
  } asr_state_s;

  localparam asr_state_s STATE_RESET = '{waitReq: 1'b1, end_of_receive_flag: 1'b1, receive_buffer_full_flag: 1'b1, default: '0};

endpackage

/* asr_status_result.sv */
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
// What this block does
// - channel state bit mirrors channel enable
// - rx full when both counters zero
// - end-of-receive sets at zero, clears on counter write
// - general overrun sticky until status read
// - data ready sets on result, clears on read
// - channel overrun sticky until status read
// - conversion done only on enabled channel
// - last result captured every conversion
// - channel result loads only when enabled
// - irq enable set writes ones only
// - irq enable clear writes ones only
// - irq view shows enabled flags
// - revision register read only, no effect
// - channel enable set writes ones only
module asr_status_result
  import asr_pkg::*;
#(
  parameter int NUM_CHAN = 8,
  parameter logic [REV_W-1:0] REVISION_NUM = 12'h100, // arbitrary value
  parameter logic [VAR_W-1:0] VARIANT_NUM = 4'h0 // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [BUS_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [BUS_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // analog core
  input asr_conv_s conv,
  output logic [MAX_CHAN-1:0] chanEnable,
  // dma receive counters
  input asr_rx_s rx,
  // interrupt
  output logic irq
);

  if (NUM_CHAN < 1 || NUM_CHAN > MAX_CHAN) begin : g_bad_chan
    $error("NUM_CHAN must lie between 1 and 8");
  end

  localparam logic [MAX_CHAN-1:0] IMPL_MASK = MAX_CHAN'((1 << NUM_CHAN) - 1);

  asr_state_s st;
  asr_state_s nxt;
  logic request;
  logic rdAck;
  logic wrAck;
  logic [BUS_W-1:0] wrData;
  logic [BUS_W-1:0] beMask;
  logic [ADDR_W-1:0] chanOfs;
  logic [2:0] chanIdx;
  logic chanHit;

  function automatic logic [BUS_W-1:0] statusOf(input asr_state_s s);
    logic [BUS_W-1:0] w;
    w = '0;
    w[EOC_LSB +: MAX_CHAN] = s.eoc;
    w[OVR_LSB +: MAX_CHAN] = s.ovr;
    w[DATA_READY_FLAG_BIT] = s.dataReady;
    w[GOVR_BIT] = s.genOvr;
    w[END_OF_RECEIVE_FLAG_BIT] = s.end_of_receive_flag;
    w[RECEIVE_BUFFER_FULL_FLAG_BIT] = s.receive_buffer_full_flag;
    return w;
  endfunction

  assign request = avs_read | avs_write;
  // the master holds the request until it sees waitrequest low
  assign rdAck = avs_read && !st.waitReq;
  assign wrAck = avs_write && !st.waitReq;
  assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wrData = avs_writedata & beMask;
  assign chanOfs = avs_address - CHAN_DATA0_OFS;
  assign chanIdx = chanOfs[4:2];
  assign chanHit = (avs_address >= CHAN_DATA0_OFS) && (avs_address <= CHAN_DATA_LAST_OFS)
                   && (avs_address[1:0] == 2'b00);

  always_comb begin
    nxt = st;

    // bus answer: one wait cycle, then waitrequest low for one cycle
    if (st.waitReq && request) begin
      nxt.waitReq = 1'b0;
      nxt.rdData = '0;
      if (avs_read) begin
        // read side effects act here, where the data is captured, so that
        // an event arriving before the ack cycle is never cleared unseen
        if (chanHit) begin
          nxt.rdData[DATA_W-1:0] = IMPL_MASK[chanIdx] ? st.chanData[chanIdx] : '0;
          nxt.eoc[chanIdx] = 1'b0;
        end else begin
          case (avs_address)
            CHEN_STATE_OFS: nxt.rdData[MAX_CHAN-1:0] = st.chanEn;
            STATUS_OFS: begin
              nxt.rdData = statusOf(st);
              nxt.ovr = '0;
              nxt.genOvr = 1'b0;
            end
            LAST_RESULT_OFS: begin
              nxt.rdData[DATA_W-1:0] = st.lastData;
              nxt.dataReady = 1'b0;
            end
            IRQ_VIEW_OFS: nxt.rdData = st.irqMask;
            REVISION_OFS: begin
              nxt.rdData[REV_LSB +: REV_W] = REVISION_NUM;
              nxt.rdData[VAR_LSB +: VAR_W] = VARIANT_NUM;
            end
            default: nxt.rdData = '0;
          endcase
        end
      end
    end else begin
      nxt.waitReq = 1'b1;
    end

    // writes take effect on the ack edge; clears come before hardware sets
    if (wrAck) begin
      case (avs_address)
        CHEN_SET_OFS: nxt.chanEn = st.chanEn | (wrData[MAX_CHAN-1:0] & IMPL_MASK);
        CHEN_CLR_OFS: nxt.chanEn = st.chanEn & ~wrData[MAX_CHAN-1:0];
        IRQ_SET_OFS: nxt.irqMask = st.irqMask | (wrData & FLAG_MASK);
        IRQ_CLR_OFS: nxt.irqMask = st.irqMask & ~wrData;
        FLAG_CLR_OFS: begin
          nxt.eoc = nxt.eoc & ~wrData[EOC_LSB +: MAX_CHAN];
          nxt.ovr = nxt.ovr & ~wrData[OVR_LSB +: MAX_CHAN];
          nxt.dataReady = nxt.dataReady & ~wrData[DATA_READY_FLAG_BIT];
          nxt.genOvr = nxt.genOvr & ~wrData[GOVR_BIT];
          nxt.end_of_receive_flag = nxt.end_of_receive_flag & ~wrData[END_OF_RECEIVE_FLAG_BIT];
        end
        default: nxt.irqMask = nxt.irqMask;
      endcase
    end

    // dma counters share this clock, so no synchroniser
    nxt.receive_buffer_full_flag = (rx.count == '0) && (rx.nextCount == '0);
    if (rx.counterWr) begin
      nxt.end_of_receive_flag = 1'b0;
    end
    if (rx.count == '0) begin
      nxt.end_of_receive_flag = 1'b1;
    end

    // a finished conversion; sets win over any clear in the same cycle
    if (conv.valid) begin
      if (nxt.dataReady) begin
        nxt.genOvr = 1'b1;
      end
      nxt.dataReady = 1'b1;
      nxt.lastData = conv.data;
      if (nxt.chanEn[conv.chan] && IMPL_MASK[conv.chan]) begin
        if (nxt.eoc[conv.chan]) begin
          nxt.ovr[conv.chan] = 1'b1;
        end
        nxt.eoc[conv.chan] = 1'b1;
        nxt.chanData[conv.chan] = conv.data;
      end
    end

    // a disabled channel never shows done; mid-conversion disable is the
    // caller's hazard and leaves result and overrun as they fall
    nxt.eoc = nxt.eoc & nxt.chanEn;

    nxt.irq = |(statusOf(nxt) & nxt.irqMask);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= STATE_RESET;
    end else begin
      st <= nxt;
    end
  end

  assign avs_readdata = st.rdData;
  assign avs_waitrequest = st.waitReq;
  assign chanEnable = st.chanEn;
  assign irq = st.irq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  bus_one_ack_a: assert property (rdAck || wrAck |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  bus_answer_a: assert property (request && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  rx_full_a: assert property ((rx.count == '0 && rx.nextCount == '0)[*2] |-> st.receive_buffer_full_flag)
    else $error("rx full flag missing with both counters zero");
  rx_not_full_a: assert property (rx.count != '0 |=> !st.receive_buffer_full_flag)
    else $error("rx full flag set with nonzero counter");
  end_rx_clear_a: assert property (rx.counterWr && rx.count != '0 |=> !st.end_of_receive_flag)
    else $error("end of receive not cleared by counter write");
  gen_ovr_a: assert property (conv.valid && st.dataReady && !request |=> st.genOvr)
    else $error("general overrun missed");
  status_clear_a: assert property (avs_read && avs_waitrequest && avs_address == STATUS_OFS
    && !conv.valid |=> st.ovr == '0 && !st.genOvr)
    else $error("status read did not clear overruns");
  data_ready_a: assert property (conv.valid |=> st.dataReady && st.lastData == $past(conv.data))
    else $error("last result or data ready not updated");
  ready_hold_a: assert property (st.dataReady && !conv.valid && !request |=> st.dataReady)
    else $error("data ready dropped without a read");
  irq_level_a: assert property (|(statusOf(st) & st.irqMask) |-> irq)
    else $error("irq low while an enabled flag is set");
  irq_low_a: assert property (!(|(statusOf(st) & st.irqMask)) |-> !irq)
    else $error("irq high with no enabled flag");
  mask_set_a: assert property (wrAck && avs_address == IRQ_SET_OFS |=>
    (st.irqMask & $past(wrData) & FLAG_MASK) == ($past(wrData) & FLAG_MASK))
    else $error("irq enable set lost a bit");
  mask_clear_a: assert property (wrAck && avs_address == IRQ_CLR_OFS |=>
    (st.irqMask & $past(wrData)) == '0)
    else $error("irq enable clear kept a bit");

  for (genvar i = 0; i < MAX_CHAN; i++) begin : g_chan_check
    eoc_enabled_a: assert property (st.eoc[i] |-> st.chanEn[i])
      else $error("done flag on a disabled channel");
    chan_hold_a: assert property (conv.valid && conv.chan == i && !st.chanEn[i] |=>
      $stable(st.chanData[i]))
      else $error("result of a disabled channel changed");
    chan_ovr_a: assert property (conv.valid && conv.chan == i && st.chanEn[i] && st.eoc[i]
      && !request |=> st.ovr[i])
      else $error("channel overrun missed");
    chan_enable_a: assert property (wrAck && avs_address == CHEN_SET_OFS && wrData[i]
      && IMPL_MASK[i] |=> chanEnable[i])
      else $error("channel enable write lost");
  end

  // decode-edge views for the checks below
  logic rdTake;
  logic [BUS_W-1:0] statusNow;
  assign rdTake = avs_read && st.waitReq;
  assign statusNow = statusOf(st);

  bus_idle_a: assert property (!request |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles running");

  status_data_a: assert property (rdTake && avs_address == STATUS_OFS |=>
    avs_readdata == $past(statusNow))
    else $error("status read returned wrong flags");

  last_data_a: assert property (rdTake && avs_address == LAST_RESULT_OFS |=>
    avs_readdata[DATA_W-1:0] == $past(st.lastData) && avs_readdata[BUS_W-1:DATA_W] == '0)
    else $error("last result read returned wrong value");

  view_data_a: assert property (rdTake && avs_address == IRQ_VIEW_OFS |=>
    avs_readdata == $past(st.irqMask))
    else $error("irq view read returned wrong mask");

  state_data_a: assert property (rdTake && avs_address == CHEN_STATE_OFS |=>
    avs_readdata[MAX_CHAN-1:0] == $past(st.chanEn) && avs_readdata[BUS_W-1:MAX_CHAN] == '0)
    else $error("channel state read returned wrong value");

  rev_data_a: assert property (rdTake && avs_address == REVISION_OFS |=>
    avs_readdata[REV_LSB +: REV_W] == REVISION_NUM && avs_readdata[VAR_LSB +: VAR_W] == VARIANT_NUM)
    else $error("revision read returned wrong fields");

  wo_irq_zero_a: assert property (rdTake && avs_address == IRQ_SET_OFS |=>
    avs_readdata == '0)
    else $error("write-only irq set register read nonzero");

  wo_chan_zero_a: assert property (rdTake && avs_address == CHEN_SET_OFS |=>
    avs_readdata == '0)
    else $error("write-only channel enable register read nonzero");

  wo_clr_zero_a: assert property (rdTake && avs_address == IRQ_CLR_OFS |=>
    avs_readdata == '0)
    else $error("write-only irq clear register read nonzero");

  last_clear_a: assert property (rdTake && avs_address == LAST_RESULT_OFS
    && !conv.valid |=> !st.dataReady)
    else $error("data ready not cleared by last result read");

  last_hold_a: assert property (!conv.valid |=> $stable(st.lastData))
    else $error("last result changed without a conversion");

  govr_hold_a: assert property (st.genOvr && !request |=> st.genOvr)
    else $error("general overrun dropped without a status read");

  data_ready_flag_rise_a: assert property (!st.dataReady && !conv.valid |=> !st.dataReady)
    else $error("data ready set without a conversion");

  govr_rise_a: assert property (!st.genOvr && !conv.valid |=> !st.genOvr)
    else $error("general overrun set without a conversion");

  set_keep_a: assert property (wrAck && avs_address == IRQ_SET_OFS |=>
    (st.irqMask & ~$past(wrData)) == ($past(st.irqMask) & ~$past(wrData)))
    else $error("irq enable set changed a zero-written bit");

  clr_keep_a: assert property (wrAck && avs_address == IRQ_CLR_OFS |=>
    (st.irqMask & ~$past(wrData)) == ($past(st.irqMask) & ~$past(wrData)))
    else $error("irq enable clear changed a zero-written bit");

  mask_idle_a: assert property (!wrAck |=> $stable(st.irqMask))
    else $error("irq mask changed without a write");

  mask_upper_a: assert property ((st.irqMask & ~FLAG_MASK) == '0)
    else $error("irq mask holds a bit outside the flags");

  rev_inert_a: assert property (wrAck && avs_address == REVISION_OFS |=>
    st.irqMask == $past(st.irqMask) && chanEnable == $past(chanEnable))
    else $error("revision write changed state");

  end_rx_set_a: assert property (rx.count == '0 |=> st.end_of_receive_flag)
    else $error("end of receive missing at zero count");

  end_rx_hold_a: assert property (st.end_of_receive_flag && !rx.counterWr && !request |=> st.end_of_receive_flag)
    else $error("end of receive dropped without a counter write");

  end_rx_low_a: assert property (!st.end_of_receive_flag && rx.count != '0 |=> !st.end_of_receive_flag)
    else $error("end of receive set with nonzero count");

  rx_full_low_a: assert property (rx.nextCount != '0 |=> !st.receive_buffer_full_flag)
    else $error("rx full flag set with nonzero next counter");

  for (genvar i = 0; i < MAX_CHAN; i++) begin : g_chan_more
    ovr_hold_a: assert property (st.ovr[i] && !request |=> st.ovr[i])
      else $error("channel overrun dropped without a status read");

    ovr_rise_a: assert property (!st.ovr[i] && !(conv.valid && conv.chan == i)
      |=> !st.ovr[i])
      else $error("channel overrun set without a result");

    chan_load_a: assert property (conv.valid && conv.chan == i && st.chanEn[i]
      && !request |=> st.chanData[i] == $past(conv.data))
      else $error("enabled channel result not loaded");

    eoc_set_a: assert property (conv.valid && conv.chan == i && st.chanEn[i]
      && !request |=> st.eoc[i])
      else $error("done flag missing after a result");

    eoc_hold_a: assert property (st.eoc[i] && !request |=> st.eoc[i])
      else $error("done flag dropped without a read");

    eoc_read_a: assert property (rdTake && avs_address == CHAN_DATA0_OFS + ADDR_W'(4 * i)
      && !conv.valid |=> !st.eoc[i])
      else $error("done flag kept after its result was read");

    chan_off_a: assert property (wrAck && avs_address == CHEN_CLR_OFS && wrData[i]
      |=> !chanEnable[i])
      else $error("channel disable write lost");

    chan_keep_a: assert property (wrAck && avs_address == CHEN_SET_OFS && !wrData[i]
      |=> chanEnable[i] == $past(chanEnable[i]))
      else $error("channel enable changed by a zero bit");
  end

endmodule

/* asr_far_model.sv */
`timescale 1ns/1ns
module asr_far_model
  import asr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bench commands
  input wire logic convReq,
  input wire logic [2:0] convChan,
  input wire logic [DATA_W-1:0] convData,
  input wire logic rxWrReq,
  input wire logic [RX_CNT_W-1:0] rxCountIn,
  input wire logic [RX_CNT_W-1:0] rxNextIn,
  // toward the block
  output asr_conv_s conv,
  output asr_rx_s rx
);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conv <= '0;
      rx <= '0;
    end else begin
      conv.valid <= convReq;
      conv.chan <= convChan;
      // result bus is not held outside the valid pulse
      conv.data <= convReq ? convData : ~conv.data;
      rx.counterWr <= rxWrReq;
      rx.count <= rxCountIn;
      rx.nextCount <= rxNextIn;
    end
  end
endmodule

/* asr_status_result_test.sv */
`timescale 1ns/1ns
module asr_status_result_test
  import asr_pkg::*;
;
  typedef struct packed {
    logic [ADDR_W-1:0] wa;
    logic [BUS_W-1:0] wd;
    logic [ADDR_W-1:0] ra;
    logic [BUS_W-1:0] ex;
  } asr_row_s;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [BUS_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [BUS_W-1:0] avs_readdata;
  logic avs_waitrequest;
  asr_conv_s conv;
  logic [MAX_CHAN-1:0] chanEnable;
  asr_rx_s rx;
  logic irq;
  logic convReq = 1'b0;
  logic [2:0] convChan = '0;
  logic [DATA_W-1:0] convData = '0;
  logic rxWrReq = 1'b0;
  logic [RX_CNT_W-1:0] rxCountIn = '0;
  logic [RX_CNT_W-1:0] rxNextIn = '0;
  logic [BUS_W-1:0] q;
  int errors = 0;
  int checked = 0;
  asr_row_s rows [8] = '{
    '{CHEN_SET_OFS, 32'h0000_0005, CHEN_STATE_OFS, 32'h0000_0005},
    '{CHEN_SET_OFS, 32'h0000_0000, CHEN_STATE_OFS, 32'h0000_0005},
    '{CHEN_CLR_OFS, 32'h0000_0001, CHEN_STATE_OFS, 32'h0000_0004},
    '{IRQ_SET_OFS, 32'h0001_0004, IRQ_VIEW_OFS, 32'h0001_0004},
    '{IRQ_CLR_OFS, 32'h0000_0004, IRQ_VIEW_OFS, 32'h0001_0000},
    '{IRQ_SET_OFS, 32'h0000_0000, IRQ_SET_OFS, 32'h0000_0000},
    '{REVISION_OFS, 32'hFFFF_FFFF, REVISION_OFS, 32'h0000_0100},
    '{8'h04, 32'hFFFF_FFFF, 8'h04, 32'h0000_0000}};
  logic [ADDR_W-1:0] resetAddr [5] = '{STATUS_OFS, LAST_RESULT_OFS, CHAN_DATA0_OFS,
    IRQ_VIEW_OFS, CHEN_STATE_OFS};

  asr_status_result dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .conv, .chanEnable, .rx, .irq);
  asr_far_model far (.sys_clk, .rst, .convReq, .convChan, .convData, .rxWrReq, .rxCountIn,
    .rxNextIn, .conv, .rx);

  always #5 sys_clk = ~sys_clk;

  task automatic chk(input logic [BUS_W-1:0] s, input logic [BUS_W-1:0] e);
    checked++;
    if (s !== e) begin
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      errors++;
    end
  endtask

  // one avalon access, held until waitrequest is sampled low at a rising edge
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      tally_and_finish;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] e);
    acc(1'b0, a, '0);
    chk(q, e);
  endtask

  task automatic ci(input logic e);
    @(negedge sys_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // enables stay fixed while a conversion runs
  task automatic cv(input logic [2:0] c, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    convReq <= 1'b1;
    convChan <= c;
    convData <= d;
    @(posedge sys_clk);
    convReq <= 1'b0;
  endtask

  task automatic rxs(input logic [RX_CNT_W-1:0] c, input logic [RX_CNT_W-1:0] n, input logic w);
    @(posedge sys_clk);
    rxCountIn <= c;
    rxNextIn <= n;
    rxWrReq <= w;
    @(posedge sys_clk);
    rxWrReq <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge sys_clk);
    errors++;
    tally_and_finish;
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      acc(1'b1, rows[i].wa, rows[i].wd);
      rdc(rows[i].ra, rows[i].ex);
    end
    // second reset in mid-run, then reset values
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (resetAddr[i]) rdc(resetAddr[i], resetAddr[i] == STATUS_OFS ? STATUS_RESET : '0);
    ci(1'b0);
    acc(1'b1, CHEN_SET_OFS, 32'h0000_0004);
    acc(1'b1, IRQ_SET_OFS, 32'h0001_0000);
    rxs(16'h0005, 16'h0003, 1'b1);
    cv(3'd2, 10'h3A5);
    rdc(STATUS_OFS, 32'h0001_0004);
    ci(1'b1);
    chk({24'h0, chanEnable}, 32'h0000_0004);
    rdc(LAST_RESULT_OFS, 32'h0000_03A5);
    rdc(STATUS_OFS, 32'h0000_0004);
    ci(1'b0);
    rdc(CHAN_DATA0_OFS + 8'h08, 32'h0000_03A5);
    cv(3'd1, 10'h111);
    rdc(CHAN_DATA0_OFS + 8'h04, 32'h0000_0000);
    rdc(LAST_RESULT_OFS, 32'h0000_0111);
    rdc(STATUS_OFS, 32'h0000_0000);
    cv(3'd2, 10'h0AA);
    cv(3'd2, 10'h155);
    rdc(STATUS_OFS, 32'h0003_0404);
    rdc(STATUS_OFS, 32'h0001_0004);
    rdc(CHAN_DATA0_OFS + 8'h08, 32'h0000_0155);
    rdc(LAST_RESULT_OFS, 32'h0000_0155);
    rxs(16'h0000, 16'h0000, 1'b1);
    rdc(STATUS_OFS, 32'h000C_0000);
    rxs(16'h0004, 16'h0000, 1'b1);
    rdc(STATUS_OFS, 32'h0000_0000);
    rxs(16'h0000, 16'h0002, 1'b0);
    rdc(STATUS_OFS, 32'h0004_0000);
    acc(1'b1, IRQ_SET_OFS, 32'h0004_0000);
    ci(1'b1);
    acc(1'b1, IRQ_CLR_OFS, 32'h0004_0000);
    ci(1'b0);
    cv(3'd2, 10'h077);
    acc(1'b1, FLAG_CLR_OFS, 32'h0001_0004);
    rdc(STATUS_OFS, 32'h0004_0000);
    ci(1'b0);
    avs_byteenable <= 4'hE;
    acc(1'b1, CHEN_SET_OFS, 32'h0000_0001);
    avs_byteenable <= 4'hF;
    rdc(CHEN_STATE_OFS, 32'h0000_0004);
    tally_and_finish;
  end
endmodule
